// ---- src/adc_host_ctrl.sv ----
// Functional notes
// - host raises read; done and data release
// - write-read: host lowers select and write
// - write-read: host waits 0.4 us after write rise before read fall
// - host leaves 500 ns between conversions
// - write low 0.5 to 50 us
`timescale 1ns/100ps
`include "adc_host_defs.svh"
module adc_host_ctrl
	import adc_host_pkg::*;
(
	input  wire logic       MCLK_I,
	input  wire logic       RST_I,
	input  wire logic       MODE_I,
	input  wire logic       STANDALONE_I,
	input  wire logic       START_I,
	output logic            BUSY_O,
	output logic            DONE_O,
	output logic            TIMEOUT_O,
	output logic [7:0]      SAMPLE_O,
	output logic            SELECT_N_O,
	output logic            READ_N_O,
	output logic            WRITE_N_O,
	output logic            WRITE_N_OE_O,
	input  wire logic       READY_N_I,
	input  wire logic       CONV_DONE_N_I,
	input  wire logic [7:0] DATA_I,
	output logic            MODE_O
);
	host_state_e       state_q;
	host_state_e       state_d;
	logic              mode_q;
	logic              mode_d;
	logic              sa_q;
	logic              sa_d;
	sample_t           sample_q;
	sample_t           sample_d;
	logic              done_q;
	logic              done_d;
	logic              tmo_q;
	logic              tmo_d;
	logic              load;
	logic [`CNT_W-1:0] load_cnt;
	logic              tdone;
	logic [`CNT_W-1:0] guard_q;
	logic [`CNT_W-1:0] guard_d;

	adc_host_timer u_timer
	(
		.MCLK_I  (MCLK_I),
		.RST_I   (RST_I),
		.load_i  (load),
		.count_i (load_cnt),
		.done_o  (tdone)
	);

	always_comb
	begin
		state_d  = state_q;
		mode_d   = mode_q;
		sa_d     = sa_q;
		sample_d = sample_q;
		done_d   = 1'b0;
		tmo_d    = tmo_q;
		guard_d  = guard_q;
		load     = 1'b0;
		load_cnt = '0;
		if (guard_q != '0)
			guard_d = guard_q - `CNT_W'(1);
		case (state_q)
		ST_IDLE:
			// a start request while busy is never taken
			if (START_I && tdone && guard_q == '0)
			begin
				mode_d = MODE_I;
				sa_d   = STANDALONE_I & MODE_I;
				tmo_d  = 1'b0;
				load   = 1'b1;
				if (MODE_I)
				begin
					state_d  = ST_WR_LOW;
					load_cnt = `CNT_W'(`CYC_UP(`T_WR_PULSE_MIN_NS));
				end
				else
				begin
					state_d  = ST_RO_SEL;
					load_cnt = `CNT_W'(`CYC_DN(`T_RDY_MAX_NS));
				end
			end
		ST_RO_SEL:
			// busy must show within T_RDY_MAX_NS of select and read falling, else the run times out
			if (!READY_N_I)
			begin
				state_d  = ST_RO_WAIT;
				load     = 1'b1;
				load_cnt = `CNT_W'(`CYC_DN(`T_CONV_READ_MAX_NS));
			end
			else if (tdone)
			begin
				tmo_d   = 1'b1;
				state_d = ST_RELEASE;
			end
		ST_RO_WAIT:
			if (!CONV_DONE_N_I)
			begin
				state_d  = ST_RD_DATA;
				load     = 1'b1;
				load_cnt = `CNT_W'(`CYC_DN(`T_INT_DATA_MAX_NS));
			end
			else if (tdone)
			begin
				tmo_d   = 1'b1;
				state_d = ST_RELEASE;
			end
		ST_WR_LOW:
			if (tdone)
			begin
				state_d  = ST_WR_WAIT;
				load     = 1'b1;
				load_cnt = sa_q ? `CNT_W'(`CYC_DN(`T_INT_WR_MAX_NS))
					: `CNT_W'(`CYC_UP(`T_WR_RD_MIN_NS));
				// done may still be low from the last run; blank it
				if (sa_q)
					guard_d = `CNT_W'(`CYC_UP(`T_INT_SA_MAX_NS));
			end
		ST_WR_WAIT:
			if (sa_q)
			begin
				// stand-alone: read tied low, take data on done
				if (!CONV_DONE_N_I && guard_q == '0)
				begin
					state_d  = ST_RD_DATA;
					load     = 1'b1;
					load_cnt = `CNT_W'(`CYC_DN(`T_INT_DATA_MAX_NS));
				end
				else if (tdone)
				begin
					tmo_d   = 1'b1;
					state_d = ST_RELEASE;
				end
			end
			else if (tdone)
			begin
				state_d  = ST_RD_LOW;
				load     = 1'b1;
				load_cnt = !CONV_DONE_N_I
					? `CNT_W'(`CYC_DN(`T_INT_DATA_MAX_NS))
					: `CNT_W'(`CYC_DN(`T_RD_DATA1_MAX_NS));
			end
		ST_RD_LOW:
			if (tdone)
				state_d = ST_RD_DATA;
		ST_RD_DATA:
			if (tdone)
			begin
				sample_d = DATA_I;
				done_d   = 1'b1;
				state_d  = ST_RELEASE;
				load     = 1'b1;
				load_cnt = `CNT_W'(`CYC_UP(`T_INT_HIGH_MAX_NS));
			end
		ST_RELEASE:
			// wait out done recovery before the gap
			if (tdone)
			begin
				state_d  = ST_GAP;
				load     = 1'b1;
				load_cnt = sa_q ? `CNT_W'(`CYC_UP(`T_INT_SA_MAX_NS))
					: `CNT_W'(`CYC_UP(`T_NEXT_MIN_NS));
			end
		ST_GAP:
			if (tdone)
			begin
				state_d = ST_IDLE;
				guard_d = `CNT_W'(`CYC_UP(`T_NEXT_MIN_NS));
			end
		default:
			state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_I)
	begin
		if (RST_I)
		begin
			state_q  <= ST_IDLE;
			mode_q   <= 1'b0;
			sa_q     <= 1'b0;
			sample_q <= '0;
			done_q   <= 1'b0;
			tmo_q    <= 1'b0;
			guard_q  <= '0;
		end
		else
		begin
			state_q  <= state_d;
			mode_q   <= mode_d;
			sa_q     <= sa_d;
			sample_q <= sample_d;
			done_q   <= done_d;
			tmo_q    <= tmo_d;
			guard_q  <= guard_d;
		end
	end

	// pins derive from state_q, sa_q and mode_q only, so they are glitch free after the flops
	assign MODE_O       = mode_q;
	assign SELECT_N_O   = !(state_q inside {ST_RO_SEL, ST_RO_WAIT, ST_WR_LOW,
		ST_WR_WAIT, ST_RD_LOW, ST_RD_DATA});
	// stand-alone read rises with done, so a later read-only start sees a fall
	assign READ_N_O     = !(sa_q
		? (state_q inside {ST_WR_LOW, ST_WR_WAIT, ST_RD_DATA})
		: (state_q inside {ST_RO_SEL, ST_RO_WAIT, ST_RD_LOW,
		ST_RD_DATA}));
	assign WRITE_N_O    = !(state_q == ST_WR_LOW);
	assign WRITE_N_OE_O = mode_q;
	assign BUSY_O       = (state_q != ST_IDLE) || (guard_q != '0);
	assign DONE_O       = done_q;
	assign TIMEOUT_O    = tmo_q;
	assign SAMPLE_O     = sample_q;
endmodule

// ---- src/adc_host_defs.svh ----
`ifndef ADC_HOST_DEFS_SVH
`define ADC_HOST_DEFS_SVH

`define CLK_PERIOD_PS        4000
// host-side timing figures in ns, counts derived at 4 ns per cycle
`define T_RDY_MAX_NS         100
`define T_CONV_READ_MAX_NS   2500
`define T_INT_HIGH_MAX_NS    225
`define T_DIS_MAX_NS         95
`define T_WR_RD_MIN_NS       400
`define T_INT_WR_MAX_NS      1300
`define T_RD_DATA1_MAX_NS    320
`define T_INT_DATA_MAX_NS    50
`define T_INT_SA_MAX_NS      270
`define T_NEXT_MIN_NS        500
`define T_WR_PULSE_MIN_NS    500
`define T_WR_PULSE_MAX_NS    50000

// least times round up, longest round down, except T_INT_HIGH_MAX_NS and T_INT_SA_MAX_NS, which round up
`define CYC_UP(ns)   (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DN(ns)   (((ns) * 1000) / `CLK_PERIOD_PS)

`define CNT_W        12

`endif

// ---- src/adc_host_pkg.sv ----
package adc_host_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RO_SEL,
		ST_RO_WAIT,
		ST_WR_LOW,
		ST_WR_WAIT,
		ST_RD_LOW,
		ST_RD_DATA,
		ST_RELEASE,
		ST_GAP
	} host_state_e;
	typedef logic [7:0] sample_t;
endpackage

// ---- src/adc_host_timer.sv ----
`timescale 1ns/100ps
`include "adc_host_defs.svh"
module adc_host_timer
	import adc_host_pkg::*;
(
	input  wire logic              MCLK_I,
	input  wire logic              RST_I,
	input  wire logic              load_i,
	input  wire logic [`CNT_W-1:0] count_i,
	output logic                   done_o
);
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (load_i)
			cnt_d = count_i;
		else if (cnt_q != '0)
			cnt_d = cnt_q - `CNT_W'(1);
	end

	always_ff @(posedge MCLK_I)
	begin
		if (RST_I)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// done ignores load so callers may gate load on done without a loop
	assign done_o = (cnt_q == '0);
endmodule

// ---- testbench/adc_host_ctrl_sva.sv ----
`timescale 1ns/100ps
module adc_host_ctrl_sva(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic MODE_O,
	input wire logic DONE_O,
	input wire logic TIMEOUT_O,
	input wire logic SELECT_N_O,
	input wire logic READ_N_O,
	input wire logic WRITE_N_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	wr_sel_a: assert property ($fell(WRITE_N_O) |-> $fell(SELECT_N_O))
		else $error("write without select");
	wr_len_a: assert property ($fell(WRITE_N_O) |-> ##124 !WRITE_N_O)
		else $error("write pulse short");
	rd_wait_a: assert property ($fell(READ_N_O) && MODE_O
		|-> $past(WRITE_N_O, 100)) else $error("read too soon");
	rd_end_a: assert property ($rose(READ_N_O) |-> DONE_O || TIMEOUT_O)
		else $error("read raised early");
	conv_gap_a: assert property ($fell(SELECT_N_O)
		|-> $past(SELECT_N_O, 125)) else $error("gap short");
	cover property (DONE_O && !MODE_O);
	cover property (DONE_O && MODE_O);
	cover property ($fell(READ_N_O) && !WRITE_N_O);
endmodule
bind adc_host_ctrl adc_host_ctrl_sva u_sva(.*);

// ---- testbench/adc_dev_model.sv ----
`timescale 1ns/100ps
module adc_dev_model(
	input  wire logic       sel_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       mode_i,
	input  wire logic       slow_i,
	input  wire logic [7:0] code_i,
	output logic            rdy_n_o,
	output logic            int_n_o,
	output logic [7:0]      d_o
);
	logic       busy;
	logic       en;
	logic [7:0] lat;
	// released bus shows inverse so a stale byte never passes
	assign d_o = en ? lat : ~lat;
	initial
	begin
		{busy, en, lat} = '0;
		{rdy_n_o, int_n_o} = 2'b11;
	end
	// mode pin moves on the same edge as the strobes; let it settle first
	always @(negedge sel_n_i)
	begin
		#1;
		if (!mode_i) rdy_n_o <= #(slow_i ? 94 : 49) 1'b0;
	end
	always @(negedge rd_n_i)
	begin
		#1;
		if (!mode_i && !busy)
		begin
			busy = 1'b1;
			#(slow_i ? 2399 : 1599);
			lat = code_i;
			{int_n_o, rdy_n_o, en, busy} = 4'b0110;
		end
		else if (mode_i && busy)
		begin
			// early read ends the conversion itself
			#(slow_i ? 299 : 199);
			lat = code_i;
			{int_n_o, en, busy} = 3'b010;
		end
	end
	always @(posedge wr_n_i)
	begin
		if (mode_i && !rd_n_i) int_n_o <= #(slow_i ? 265 : 175) 1'b1;
		if (mode_i && !busy)
		begin
			busy = 1'b1;
			#(slow_i ? 1250 : 800);
			if (busy)
			begin
				lat = code_i;
				{int_n_o, busy} = 2'b00;
			end
		end
	end
	always @(negedge int_n_o) en <= #(slow_i ? 45 : 20) 1'b1;
	always @(posedge rd_n_i)
	begin
		int_n_o <= #(slow_i ? 220 : 125) 1'b1;
		en <= #(slow_i ? 90 : 70) 1'b0;
	end
endmodule

// ---- testbench/adc_host_handshake_control_bench.sv ----
`timescale 1ns/100ps
module adc_host_handshake_control_bench;
	import adc_host_pkg::*;
	logic    MCLK_I, RST_I, MODE_I, STANDALONE_I, START_I, slow;
	logic    BUSY_O, DONE_O, TIMEOUT_O, SELECT_N_O, READ_N_O;
	logic    WRITE_N_O, WRITE_N_OE_O, MODE_O, rdy_n, CONV_DONE_N_I;
	sample_t code, SAMPLE_O, DATA_I;
	wire     READY_N_I = WRITE_N_OE_O ? WRITE_N_O : rdy_n;
	int      n_fail, samples_checked;
	adc_host_ctrl u_adc_host_ctrl (
		.MCLK_I        (MCLK_I),
		.RST_I         (RST_I),
		.MODE_I        (MODE_I),
		.STANDALONE_I  (STANDALONE_I),
		.START_I       (START_I),
		.BUSY_O        (BUSY_O),
		.DONE_O        (DONE_O),
		.TIMEOUT_O     (TIMEOUT_O),
		.SAMPLE_O      (SAMPLE_O),
		.SELECT_N_O    (SELECT_N_O),
		.READ_N_O      (READ_N_O),
		.WRITE_N_O     (WRITE_N_O),
		.WRITE_N_OE_O  (WRITE_N_OE_O),
		.READY_N_I     (READY_N_I),
		.CONV_DONE_N_I (CONV_DONE_N_I),
		.DATA_I        (DATA_I),
		.MODE_O        (MODE_O)
	);
	adc_dev_model u_adc_dev_model (
		.sel_n_i (SELECT_N_O),
		.rd_n_i  (READ_N_O),
		.wr_n_i  (READY_N_I),
		.mode_i  (MODE_O),
		.slow_i  (slow),
		.code_i  (code),
		.rdy_n_o (rdy_n),
		.int_n_o (CONV_DONE_N_I),
		.d_o     (DATA_I)
	);
	task automatic check(input sample_t got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fin(input sample_t c);
		int k;
		k = 0;
		do @(negedge MCLK_I); while (DONE_O !== 1'b1 && ++k < 4000);
		check({7'h00, DONE_O}, 8'h01);
		check(SAMPLE_O, c);
		check({7'h00, TIMEOUT_O}, 8'h00);
	endtask
	task automatic run(input logic m, s, l, input sample_t c);
		while (BUSY_O !== 1'b0) @(negedge MCLK_I);
		@(posedge MCLK_I);
		{MODE_I, STANDALONE_I, slow, code, START_I} <= {m, s, l, c, 1'b1};
		@(posedge MCLK_I);
		START_I <= 1'b0;
		@(negedge MCLK_I);
		check({5'h00, BUSY_O, MODE_O, WRITE_N_OE_O}, {5'h00, 1'b1, m, m});
		fin(c);
	endtask
	task automatic t_read;
		run(1'b0, 1'b0, 1'b0, 8'h5A);
		run(1'b0, 1'b0, 1'b1, 8'hFF);
		$display("read-only test done");
	endtask
	task automatic t_wrrd;
		run(1'b1, 1'b0, 1'b0, 8'h00);
		run(1'b1, 1'b0, 1'b1, 8'hA5);
		$display("write-read test done");
	endtask
	task automatic t_alone;
		run(1'b1, 1'b1, 1'b0, 8'h81);
		run(1'b1, 1'b1, 1'b1, 8'h7E);
		$display("stand-alone test done");
	endtask
	task automatic t_gap;
		int k;
		run(1'b0, 1'b0, 1'b0, 8'h3C);
		// start held through the guard must wait, not restart
		k = 0;
		@(posedge MCLK_I);
		{code, START_I} <= {8'hC3, 1'b1};
		do @(negedge MCLK_I); while (SELECT_N_O !== 1'b0 && ++k < 2000);
		check({7'h00, SELECT_N_O}, 8'h00);
		check({7'h00, k >= 125}, 8'h01);
		@(posedge MCLK_I);
		START_I <= 1'b0;
		fin(8'hC3);
		$display("gap test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		MCLK_I = 1'b0;
		forever #2 MCLK_I = ~MCLK_I;
	end
	initial
	begin
		#100000;
		n_fail++;
		results;
	end
	initial
	begin
		{RST_I, MODE_I, STANDALONE_I, START_I, slow} = 5'b10000;
		code = 8'h00;
		n_fail = 0;
		samples_checked = 0;
		repeat (3) @(posedge MCLK_I);
		RST_I <= 1'b0;
		repeat (130) @(posedge MCLK_I);
		t_read;
		t_wrrd;
		t_alone;
		t_gap;
		results;
	end
endmodule
